/* File: hdl/octal_serial_ctrl.sv */
`timescale 1ns/10ps
// How it works
// - Select line active low, may act as chip select.
// - Serial output released while select is high.
// - Launch and sample on serial clock rising edge.
// - Select falling loads sensed states into output shifter, or the inverted command during thermal fault.
// - One bit in and out per clock.
// - Channel one first, channel eight last.
// - Select rising loads command, drivers switch together.
// - Eight-bit command acts only on select rising.
// - First sense bit driven within the ready delay.
// - Thermal fault clears on valid frame after cooling.
module octal_serial_ctrl (
	input  wire logic                         i_core_clk,
	input  wire logic                         i_reset_n,
	input  wire logic                         i_sel_n,
	input  wire logic                         i_sclk,
	input  wire logic                         i_sdi,
	input  wire logic [drv_pkg::CHANNELS-1:0] i_output_sense_bit,
	input  wire logic                         i_thermal_trip,
	output logic                              o_sdo,
	output logic                              o_sdo_oe,
	output logic [drv_pkg::CHANNELS-1:0]      o_drive_on,
	output logic                              o_thermal_fault
);
	import drv_pkg::*;

	// The sampler delay must fit inside the ready window, and a serial clock
	// half period must outlast the sampler so no edge is missed.
	if (SYNC_STAGES + 2 >= DATA_READY_MAX_CYCLES ||
		SCLK_HALF_MIN_CYCLES < SYNC_STAGES + 2) begin : g_timing_check
		$error("Core clock too slow for the serial link timing.");
	end

	link_if link ();

	link_sampler u_sampler (
		.i_core_clk         (i_core_clk),
		.i_reset_n          (i_reset_n),
		.i_sel_n            (i_sel_n),
		.i_sclk             (i_sclk),
		.i_sdi              (i_sdi),
		.i_output_sense_bit (i_output_sense_bit),
		.i_thermal_trip     (i_thermal_trip),
		.link               (link.sampler)
	);

	link_state_t         state;
	logic [CHANNELS-1:0] in_shift;
	logic [CHANNELS-1:0] out_shift;
	logic [2:0]          bit_count;
	logic                clocked;
	logic [CHANNELS-1:0] command;
	logic                fault;
	link_state_t         next_state;
	logic [CHANNELS-1:0] next_in_shift;
	logic [CHANNELS-1:0] next_out_shift;
	logic [2:0]          next_bit_count;
	logic                next_clocked;
	logic [CHANNELS-1:0] next_command;
	logic                next_fault;
	logic                next_sdo;
	logic                next_sdo_oe;
	logic [CHANNELS-1:0] next_drive_on;

	////////////////////////////////////////////////////////////////////////////////
	// Frame tracking, shifting, command transfer and thermal latch.
	always_comb begin
		next_state = state;
		next_in_shift = in_shift;
		next_out_shift = out_shift;
		next_bit_count = bit_count;
		next_clocked = clocked;
		next_command = command;
		next_fault = fault | link.trip;
		next_sdo = o_sdo;
		next_sdo_oe = o_sdo_oe;
		unique case (state)
			LINK_IDLE: begin
				next_sdo_oe = 1'b0;
				if (link.sel_fall) begin
					next_state = LINK_FRAME;
					// In fault every sense bit reads the opposite of its
					// request, which is how the master spots a shutdown.
					next_out_shift = next_fault ? ~command : link.sense;
					next_sdo = next_out_shift[0];
					next_sdo_oe = 1'b1;
					next_bit_count = 3'h0;
					next_clocked = 1'b0;
				end
			end
			LINK_FRAME: begin
				if (link.sel_rise) begin
					next_state = LINK_IDLE;
					next_sdo_oe = 1'b0;
					next_command = in_shift;
					// Only a whole number of bytes with the die cooled clears it.
					if (clocked && bit_count == 3'h0 && !link.trip) begin
						next_fault = 1'b0;
					end
				end else if (link.sclk_rise) begin
					// Sample and launch on the same edge; older bits fall off
					// the far end, so dummy leading bytes drop out naturally.
					next_in_shift = {link.sdi, in_shift[CHANNELS-1:1]};
					next_out_shift = {1'b0, out_shift[CHANNELS-1:1]};
					next_sdo = out_shift[1];
					next_bit_count = bit_count + 3'h1;
					next_clocked = 1'b1;
				end
			end
		endcase
		// Drivers follow the command except while the thermal fault holds.
		next_drive_on = next_fault ? '0 : next_command;
		if (!i_reset_n) begin
			next_state = LINK_IDLE;
			next_in_shift = COMMAND_RESET;
			next_out_shift = COMMAND_RESET;
			next_bit_count = 3'h0;
			next_clocked = 1'b0;
			next_command = COMMAND_RESET;
			next_fault = 1'b0;
			next_sdo = SDO_RESET;
			next_sdo_oe = 1'b0;
			next_drive_on = COMMAND_RESET;
		end
	end

	always_ff @(posedge i_core_clk) begin
		state <= next_state;
		in_shift <= next_in_shift;
		out_shift <= next_out_shift;
		bit_count <= next_bit_count;
		clocked <= next_clocked;
		command <= next_command;
		fault <= next_fault;
		o_sdo <= next_sdo;
		o_sdo_oe <= next_sdo_oe;
		o_drive_on <= next_drive_on;
		o_thermal_fault <= next_fault;
	end

endmodule // octal_serial_ctrl

/* File: hdl/drv_pkg.sv */
package drv_pkg;

	// Number of driver channels and the width of one serial exchange.
	localparam int CHANNELS = 8;
	localparam int FRAME_BITS = 8;

	// Core clock period and the link timing figures it must honour.
	localparam int CORE_CLK_PERIOD_NS = 25;
	localparam int SCLK_MAX_FREQ_KHZ = 500;
	localparam int DATA_READY_MAX_NS = 2000;
	localparam int SYNC_STAGES = 2;

	// Cycle counts derived from the figures above.
	localparam int SCLK_HALF_MIN_CYCLES =
		(1000000 / SCLK_MAX_FREQ_KHZ) / 2 / CORE_CLK_PERIOD_NS;
	localparam int DATA_READY_MAX_CYCLES = DATA_READY_MAX_NS / CORE_CLK_PERIOD_NS;

	// Reset values of the command and of the serial output pin.
	localparam logic [CHANNELS-1:0] COMMAND_RESET = 8'h00;
	localparam logic SDO_RESET = 1'b0;

	// Frame tracker states.
	typedef enum logic [1:0] {
		LINK_IDLE  = 2'b01,
		LINK_FRAME = 2'b10
	} link_state_t;

endpackage

/* File: hdl/link_if.sv */
`timescale 1ns/10ps
// Synchronised link events handed from the pin sampler to the frame logic.
interface link_if;
	logic                          sel_fall;
	logic                          sel_rise;
	logic                          sclk_rise;
	logic                          sdi;
	logic [drv_pkg::CHANNELS-1:0]  sense;
	logic                          trip;

	modport sampler (output sel_fall, sel_rise, sclk_rise, sdi, sense, trip);
	modport core (input sel_fall, sel_rise, sclk_rise, sdi, sense, trip);
endinterface

/* File: hdl/link_sampler.sv */
`timescale 1ns/10ps
// Brings every pin except reset into the core clock domain and finds link edges.
module link_sampler (
	input  wire logic                         i_core_clk,
	input  wire logic                         i_reset_n,
	input  wire logic                         i_sel_n,
	input  wire logic                         i_sclk,
	input  wire logic                         i_sdi,
	input  wire logic [drv_pkg::CHANNELS-1:0] i_output_sense_bit,
	input  wire logic                         i_thermal_trip,
	link_if.sampler                           link
);
	import drv_pkg::*;

	localparam int W = CHANNELS + 4;

	logic [W-1:0] meta;
	logic [W-1:0] sync;
	logic         sel_prev;
	logic         sclk_prev;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;
	logic         next_sel_prev;
	logic         next_sclk_prev;

	////////////////////////////////////////////////////////////////////////////////
	// Two flip-flops per pin; edges compare the second stage with a third copy
	// so the first stage is never read by logic. Select resets high (idle).
	always_comb begin
		next_meta = {i_thermal_trip, i_output_sense_bit, i_sdi, i_sclk, i_sel_n};
		next_sync = meta;
		next_sel_prev = sync[0];
		next_sclk_prev = sync[1];
		if (!i_reset_n) begin
			next_meta = {{(W-2){1'b0}}, 2'b11};
			next_sync = {{(W-2){1'b0}}, 2'b11};
			next_sel_prev = 1'b1;
			next_sclk_prev = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		meta <= next_meta;
		sync <= next_sync;
		sel_prev <= next_sel_prev;
		sclk_prev <= next_sclk_prev;
	end

	// Edge pulses; a clock edge counts only while the device is selected.
	assign link.sel_fall = sel_prev & ~sync[0];
	assign link.sel_rise = ~sel_prev & sync[0];
	assign link.sclk_rise = ~sclk_prev & sync[1] & ~sync[0];
	assign link.sdi = sync[2];
	assign link.sense = sync[CHANNELS+2:3];
	assign link.trip = sync[W-1];

endmodule // link_sampler

/* File: bench/serial_ctrl_properties.sv */
`timescale 1ns/10ps
// Pin-level checks; bounds allow for the three-edge pin synchroniser.
module serial_ctrl_properties (
	input wire logic                         i_core_clk,
	input wire logic                         i_reset_n,
	input wire logic                         i_sel_n,
	input wire logic                         i_sclk,
	input wire logic                         i_sdi,
	input wire logic [drv_pkg::CHANNELS-1:0] i_output_sense_bit,
	input wire logic                         i_thermal_trip,
	input wire logic                         o_sdo,
	input wire logic                         o_sdo_oe,
	input wire logic [drv_pkg::CHANNELS-1:0] o_drive_on,
	input wire logic                         o_thermal_fault
);
	import drv_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	oe_rise_a: assert property ($fell(i_sel_n) |-> ##[1:80] o_sdo_oe)
		else $error("data pin late");
	oe_fall_a: assert property ($rose(i_sel_n) |-> ##[1:8] !o_sdo_oe)
		else $error("data pin kept");
	pin_release_a: assert property (i_sel_n[*6] |-> !o_sdo_oe)
		else $error("driving while deselected");
	frame_drive_a: assert property ((!i_sel_n)[*8] |-> o_sdo_oe)
		else $error("not driving in frame");
	first_bit_a: assert property ($rose(o_sdo_oe) && !o_thermal_fault |->
		o_sdo == i_output_sense_bit[0])
		else $error("wrong first bit");
	bit_hold_a: assert property ((!i_sel_n && i_sclk)[*8] |-> $stable(o_sdo))
		else $error("bit moved without clock");
	cmd_only_a: assert property ($changed(o_drive_on) && !o_thermal_fault &&
		!$past(o_thermal_fault) |-> i_sel_n)
		else $error("drivers moved in frame");
	fault_off_a: assert property (o_thermal_fault && $past(o_thermal_fault) |->
		o_drive_on == 8'h00)
		else $error("drivers on in fault");
	cover property ($rose(o_sdo_oe));
	cover property ($rose(o_thermal_fault));
	cover property ($fell(o_thermal_fault));
endmodule // serial_ctrl_properties

/* File: bench/spi_master.sv */
`timescale 1ns/10ps
// Serial master: clock idles high, 200 ns period, 3 us lead, 1 us tail.
module spi_master (
	input  wire logic i_core_clk,
	input  wire logic i_sdo,
	output logic      o_sel_n = 1'b1,
	output logic      o_sclk = 1'b1,
	output logic      o_sdi = 1'b0
);
	// A deselected data line toggles, so a stale bit cannot pass as driven.
	always @(posedge i_core_clk) begin
		if (o_sel_n) begin
			o_sdi <= ~o_sdi;
		end
	end
	// One frame of n clocks; the last eight carry cmd, any before it its inverse.
	task automatic xfer(input logic [7:0] cmd, input int n, output logic [7:0] got);
		got = 8'h00;
		o_sel_n <= 1'b0;
		repeat (120) @(posedge i_core_clk);
		for (int k = 0; k < n; k++) begin
			o_sclk <= 1'b0;
			o_sdi <= (k + 8 >= n) ? cmd[(k + 8 - n) % 8] : ~cmd[k % 8];
			repeat (4) @(posedge i_core_clk);
			o_sclk <= 1'b1;
			if (k + 8 >= n) begin
				got[(k + 8 - n) % 8] = i_sdo;
			end
			repeat (4) @(posedge i_core_clk);
		end
		repeat (40) @(posedge i_core_clk);
		// No load hangs on the drivers here, so opposite commands need no spacing.
		o_sel_n <= 1'b1;
		repeat (8) @(posedge i_core_clk);
	endtask
endmodule // spi_master

/* File: bench/tb.sv */
`timescale 1ns/10ps
// Frames come from the master model; sense and trip are driven here.
module tb;
	import drv_pkg::*;
	logic                core_clk = 1'b0;
	logic                reset_n = 1'b0;
	logic                trip = 1'b0;
	logic [CHANNELS-1:0] sense = 8'h00;
	logic                sel_n, sclk, sdi, sdo, sdo_oe, fault;
	// A released data pin shows the wrong level, so a late enable is caught.
	wire                 sdo_line = sdo_oe ? sdo : ~sdo;
	logic [CHANNELS-1:0] drive;
	logic [7:0]          got;
	int                  n_fail = 0;
	int                  n_tests = 0;
	int                  cycles = 0;
	always #12.5 core_clk = ~core_clk;
	spi_master i_mst (.i_core_clk(core_clk), .i_sdo(sdo_line), .o_sel_n(sel_n), .o_sclk(sclk),
		.o_sdi(sdi));
	octal_serial_ctrl i_dut (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_sel_n(sel_n),
		.i_sclk(sclk), .i_sdi(sdi), .i_output_sense_bit(sense), .i_thermal_trip(trip),
		.o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_drive_on(drive), .o_thermal_fault(fault));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// A hang ends the run as a failure rather than running on.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			finish_test();
		end
	end
	// Single set bits prove the order; the command is checked only after select has risen.
	task automatic t_order();
		for (int k = 0; k < 2; k++) begin
			sense <= k ? 8'hA5 : 8'h01;
			repeat (4) @(posedge core_clk);
			i_mst.xfer(k ? 8'h3C : 8'h80, 8, got);
			check("sense", got, k ? 8'hA5 : 8'h01);
			check("drive", drive, k ? 8'h3C : 8'h80);
			check("oe", {7'h00, sdo_oe}, 8'h00);
		end
	endtask
	// Sixteen clocks keep the last eight; three clocks push old bits down.
	task automatic t_long();
		i_mst.xfer(8'h5A, 16, got);
		check("drive16", drive, 8'h5A);
		i_mst.xfer(8'hE0, 3, got);
		check("drive3", drive, 8'hEB);
	endtask
	// The fault holds while hot and after a short frame, and clears on a full one.
	task automatic t_fault();
		trip <= 1'b1;
		repeat (10) @(posedge core_clk);
		check("fault", {7'h00, fault}, 8'h01);
		check("fault drive", drive, 8'h00);
		i_mst.xfer(8'h0F, 8, got);
		check("hot sense", got, 8'h14);
		check("hot", {7'h00, fault}, 8'h01);
		trip <= 1'b0;
		i_mst.xfer(8'h33, 3, got);
		check("short", {7'h00, fault}, 8'h01);
		i_mst.xfer(8'hC3, 8, got);
		check("fault sense", got, 8'hDE);
		check("cleared", {7'h00, fault}, 8'h00);
		check("after", drive, 8'hC3);
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		check("reset drive", drive, 8'h00);
		check("reset oe", {7'h00, sdo_oe}, 8'h00);
		repeat (3) @(posedge core_clk);
		t_order();
		t_long();
		t_fault();
		finish_test();
	end
endmodule // tb
bind octal_serial_ctrl serial_ctrl_properties i_props (.i_core_clk, .i_reset_n, .i_sel_n,
	.i_sclk, .i_sdi, .i_output_sense_bit, .i_thermal_trip, .o_sdo, .o_sdo_oe, .o_drive_on,
	.o_thermal_fault);
